// >>> src/lpiv_cfg.svh
`ifndef LPIV_CFG_SVH
`define LPIV_CFG_SVH
`define VEC_BASE      16'hFFE0
`define VEC_RESET     16'hFFFE
`define VEC_NMI       16'hFFFC
`define VEC_TMR0      16'hFFF2
`define VEC_TMR1      16'hFFF0
`define VEC_PORT2     16'hFFE6
`define VEC_PORT1     16'hFFE4
`define PRI_RESET     4'hF
`define PRI_NMI       4'hE
`define PRI_TMR0      4'h9
`define PRI_TMR1      4'h8
`define PRI_PORT2     4'h3
`define PRI_PORT1     4'h2
`define ADDR_CTRL     4'h0
`define ADDR_STATUS   4'h1
`define ADDR_CLEAR    4'h2
`define ADDR_ENABLE   4'h3
`define ADDR_STATE    4'h4
`define CTRL_GIE_BIT  0
`define CTRL_DCO_BIT  1
`define CTRL_LVL_LSB  4
`define CTRL_SLEEP_BIT 7
`define CTRL_RESET    8'h00
`define IRQ_RESET     8'h00
`endif

// >>> src/lpiv_pkg.sv
package lpiv_pkg;
	typedef enum logic [5:0] {
		MODE_RUN = 6'h01,
		MODE_L0  = 6'h02,
		MODE_L1  = 6'h04,
		MODE_L2  = 6'h08,
		MODE_L3  = 6'h10,
		MODE_L4  = 6'h20
	} power_mode_e;
	// clock and oscillator gating seen by the clock module
	typedef struct packed {
		logic main_cpu_clock_en;
		logic peripheral_clock_en;
		logic auxiliary_clock_en;
		logic dco_bias_en;
		logic crystal_en;
		logic cpu_halt;
	} clock_ctrl_s;
	typedef struct packed {
		logic        nmi_pin_flag;
		logic        osc_fault_flag;
		logic        flash_access_violation_flag;
		logic        nmi_pin_en;
		logic        osc_fault_en;
		logic        flash_access_en;
	} nmi_src_s;
	typedef struct packed {
		logic       ccr0_flag;
		logic [1:0] ccr12_flags;
		logic       timer_overflow_flag;
		logic [7:0] port_one_edge_flags;
		logic [7:0] port_two_edge_flags;
	} periph_req_s;
	typedef struct packed {
		logic        take;
		logic [15:0] vector_addr;
		logic [3:0]  priority_lvl;
	} grant_s;
endpackage : lpiv_pkg

// >>> src/lowpower_interrupt_vectoring.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lpiv_cfg.svh"
module lowpower_interrupt_vectoring #(
	parameter int ADDR_W = 16
) (
	input  wire logic                  core_clk_i,   // 100 MHz clock
	input  wire logic                  rst_i,        // sync reset, high
	input  wire logic                  por_i,        // power-up pulse
	input  wire logic                  ext_rst_i,    // external reset pin
	input  wire logic                  watchdog_flag_i,        // expiry
	input  wire logic                  flash_key_violation_flag_i, // key
	input  wire lpiv_pkg::nmi_src_s    nmi_i,        // prio 14 sources
	input  wire lpiv_pkg::periph_req_s periph_i,     // module-held flags
	input  wire logic                  cpu_ack_i,    // cpu took grant
	input  wire logic                  cpu_reti_i,   // handler return
	input  wire logic [15:0]           vec_data_i,   // word read at vec
	input  wire logic [3:0]            reg_addr_i,   // register address
	input  wire logic [7:0]            reg_wdata_i,  // write data
	input  wire logic                  reg_wr_i,     // write strobe
	input  wire logic                  reg_rd_i,     // read strobe
	output logic [7:0]                 reg_rdata_o,  // read data
	output logic                       sys_reset_o,  // reset request
	output lpiv_pkg::grant_s           grant_o,      // vector fetch req
	output logic [15:0]                pc_load_o,    // handler address
	output logic                       pc_load_en_o, // load pc pulse
	output lpiv_pkg::clock_ctrl_s      clk_ctrl_o,   // clock gating
	output logic                       irq_o         // status interrupt
);
	import lpiv_pkg::*;

	initial begin
		if (ADDR_W != 16)
			$error("only a 16-bit address space is served");
	end

	// =========================================================
	// reset sources
	// =========================================================
	wire reset_src = por_i | ext_rst_i | watchdog_flag_i
		| flash_key_violation_flag_i;

	// =========================================================
	// request collection and priority
	// =========================================================
	logic [7:0] ctrl;
	wire gie       = ctrl[`CTRL_GIE_BIT];
	wire dco_used  = ctrl[`CTRL_DCO_BIT];
	wire [2:0] lvl = ctrl[`CTRL_LVL_LSB+2:`CTRL_LVL_LSB];
	wire sleeping  = ctrl[`CTRL_SLEEP_BIT];

	// global enable does not mask these, own enables do
	wire req_nmi = (nmi_i.nmi_pin_flag & nmi_i.nmi_pin_en)
		| (nmi_i.osc_fault_flag & nmi_i.osc_fault_en)
		| (nmi_i.flash_access_violation_flag
		& nmi_i.flash_access_en);
	wire req_t0 = gie & periph_i.ccr0_flag;
	wire req_t1 = gie & (|periph_i.ccr12_flags
		| periph_i.timer_overflow_flag);
	wire req_p2 = gie & (|periph_i.port_two_edge_flags);
	wire req_p1 = gie & (|periph_i.port_one_edge_flags);
	// flags stay in their modules; only the or of each group is seen
	wire any_req = req_nmi | req_t0 | req_t1 | req_p2 | req_p1;

	// highest priority first; vectors all sit at or above VEC_BASE
	wire [15:0] sel_vec =
		req_nmi ? `VEC_NMI :
		req_t0  ? `VEC_TMR0 :
		req_t1  ? `VEC_TMR1 :
		req_p2  ? `VEC_PORT2 : `VEC_PORT1;
	wire [3:0] sel_pri =
		req_nmi ? `PRI_NMI :
		req_t0  ? `PRI_TMR0 :
		req_t1  ? `PRI_TMR1 :
		req_p2  ? `PRI_PORT2 : `PRI_PORT1;

	// =========================================================
	// fetch sequencer
	// =========================================================
	logic       pending;
	logic       in_handler;
	logic [15:0] pend_vec;
	logic [3:0]  pend_pri;
	logic        load_pc;
	logic [15:0] pc_val;
	logic        reset_vec;

	// a fetch is requested and held until the cpu acks; data arrive with the ack
	wire start_fetch = !pending & !in_handler & any_req;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			// leaving reset the cpu must first fetch its start vector
			pending    <= 1'b1;
			reset_vec  <= 1'b1;
			pend_vec   <= `VEC_RESET;
			pend_pri   <= `PRI_RESET;
			in_handler <= 1'b0;
		end else if (reset_src) begin
			pending    <= 1'b1;
			reset_vec  <= 1'b1;
			pend_vec   <= `VEC_RESET;
			pend_pri   <= `PRI_RESET;
			in_handler <= 1'b0;
		end else if (pending & cpu_ack_i) begin
			pending    <= 1'b0;
			reset_vec  <= 1'b0;
			in_handler <= !reset_vec;
		end else if (start_fetch) begin
			pending  <= 1'b1;
			pend_vec <= sel_vec;
			pend_pri <= sel_pri;
		end else if (cpu_reti_i) begin
			in_handler <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			load_pc <= 1'b0;
			pc_val  <= 16'h0000;
		end else begin
			load_pc <= pending & cpu_ack_i & !reset_src;
			if (pending & cpu_ack_i)
				pc_val <= vec_data_i;
		end
	end

	assign grant_o.take         = pending;
	assign grant_o.vector_addr  = pend_vec;
	assign grant_o.priority_lvl = pend_pri;
	assign pc_load_o            = pc_val;
	assign pc_load_en_o         = load_pc;
	assign sys_reset_o          = reset_src;

	// =========================================================
	// operating mode
	// =========================================================
	// sleep bit is ignored while a fetch is pending or a handler runs and applies again on return
	power_mode_e mode;
	wire awake_now = in_handler | pending;
	wire eff_sleep = sleeping & !awake_now;

	always_comb begin
		if (!eff_sleep)
			mode = MODE_RUN;
		else begin
			case (lvl)
				3'h0:    mode = MODE_L0;
				3'h1:    mode = MODE_L1;
				3'h2:    mode = MODE_L2;
				3'h3:    mode = MODE_L3;
				default: mode = MODE_L4;
			endcase
		end
	end

	always_comb begin
		clk_ctrl_o = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		case (mode)
			MODE_RUN: ;
			MODE_L0: begin
				clk_ctrl_o.main_cpu_clock_en = 1'b0;
				clk_ctrl_o.cpu_halt          = 1'b1;
			end
			MODE_L1: begin
				clk_ctrl_o.main_cpu_clock_en = 1'b0;
				clk_ctrl_o.cpu_halt          = 1'b1;
				clk_ctrl_o.dco_bias_en       = dco_used;
			end
			MODE_L2: begin
				clk_ctrl_o.main_cpu_clock_en   = 1'b0;
				clk_ctrl_o.peripheral_clock_en = 1'b0;
				clk_ctrl_o.cpu_halt            = 1'b1;
			end
			MODE_L3: begin
				clk_ctrl_o.main_cpu_clock_en   = 1'b0;
				clk_ctrl_o.peripheral_clock_en = 1'b0;
				clk_ctrl_o.dco_bias_en         = 1'b0;
				clk_ctrl_o.cpu_halt            = 1'b1;
			end
			default: begin
				clk_ctrl_o = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
					1'b1};
			end
		endcase
	end

	// =========================================================
	// registers and status interrupt
	// =========================================================
	logic [7:0] status;
	logic [7:0] irq_en;
	wire [7:0] events = {3'h0, reset_src, req_nmi, req_t0, req_t1,
		req_p2 | req_p1};
	wire wr_ctrl  = reg_wr_i & (reg_addr_i == `ADDR_CTRL);
	wire wr_clear = reg_wr_i & (reg_addr_i == `ADDR_CLEAR);
	wire wr_en    = reg_wr_i & (reg_addr_i == `ADDR_ENABLE);
	wire [7:0] rd_mux =
		(reg_addr_i == `ADDR_CTRL)   ? ctrl :
		(reg_addr_i == `ADDR_STATUS) ? status :
		(reg_addr_i == `ADDR_ENABLE) ? irq_en :
		(reg_addr_i == `ADDR_STATE)  ? {2'h0, mode} : 8'h00;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ctrl        <= `CTRL_RESET;
			status      <= `IRQ_RESET;
			irq_en      <= `IRQ_RESET;
			reg_rdata_o <= 8'h00;
		end else begin
			if (reset_src)
				ctrl <= `CTRL_RESET;
			else if (wr_ctrl)
				ctrl <= reg_wdata_i;
			// a set in the same cycle as its clear wins
			status <= (status & ~(wr_clear ? reg_wdata_i : 8'h00))
				| events;
			if (wr_en)
				irq_en <= reg_wdata_i;
			reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
		end
	end
	assign irq_o = |(status & irq_en);

	// =========================================================
	// checks
	// =========================================================
	sequence s_ack;
		pending & cpu_ack_i & !reset_src;
	endsequence
	property p_reset_vec;
		@(posedge core_clk_i) disable iff (rst_i)
		reset_src |=> pending & (pend_vec == 16'hFFFE);
	endproperty
	a_reset_vec: assert property (p_reset_vec)
		else $error("reset did not select top vector");
	property p_pc_load;
		@(posedge core_clk_i) disable iff (rst_i)
		s_ack |=> pc_load_en_o & (pc_load_o == $past(vec_data_i));
	endproperty
	a_pc_load: assert property (p_pc_load)
		else $error("pc not loaded from vector");
	property p_vec_range;
		@(posedge core_clk_i) disable iff (rst_i)
		pending |-> pend_vec >= 16'hFFE0;
	endproperty
	a_vec_range: assert property (p_vec_range)
		else $error("vector outside top region");
	property p_nmi_no_gie;
		@(posedge core_clk_i) disable iff (rst_i)
		(start_fetch & !reset_src & !gie & req_nmi)
			|=> pend_vec == 16'hFFFC;
	endproperty
	a_nmi_no_gie: assert property (p_nmi_no_gie)
		else $error("nmi group masked by global enable");
	property p_prio;
		@(posedge core_clk_i) disable iff (rst_i)
		(start_fetch & !reset_src & req_t0 & !req_nmi)
			|=> pend_pri == 4'h9;
	endproperty
	a_prio: assert property (p_prio)
		else $error("wrong priority granted");
	property p_l4;
		@(posedge core_clk_i) disable iff (rst_i)
		mode == MODE_L4 |-> !clk_ctrl_o.crystal_en
			& !clk_ctrl_o.auxiliary_clock_en;
	endproperty
	a_l4: assert property (p_l4)
		else $error("level 4 left a clock running");
	property p_wake;
		@(posedge core_clk_i) disable iff (rst_i)
		pending |-> !clk_ctrl_o.cpu_halt;
	endproperty
	a_wake: assert property (p_wake)
		else $error("cpu halted during vectoring");
	property p_l3;
		@(posedge core_clk_i) disable iff (rst_i)
		mode == MODE_L3 |-> clk_ctrl_o.auxiliary_clock_en
			& !clk_ctrl_o.dco_bias_en;
	endproperty
	a_l3: assert property (p_l3)
		else $error("level 3 gating wrong");
	// any request that outranks both port groups
	wire above_port = req_nmi | req_t0 | req_t1;
	property p_nmi_vec;
		@(posedge core_clk_i) disable iff (rst_i)
		(start_fetch & !reset_src & req_nmi)
			|=> (pend_vec == 16'hFFFC) & (pend_pri == 4'hE);
	endproperty
	a_nmi_vec: assert property (p_nmi_vec)
		else $error("nmi group took the wrong vector");
	property p_t0_vec;
		@(posedge core_clk_i) disable iff (rst_i)
		(start_fetch & !reset_src & !req_nmi & req_t0)
			|=> (pend_vec == 16'hFFF2);
	endproperty
	a_t0_vec: assert property (p_t0_vec)
		else $error("timer channel zero took the wrong vector");
	property p_t1_vec;
		@(posedge core_clk_i) disable iff (rst_i)
		(start_fetch & !reset_src & !req_nmi & !req_t0 & req_t1)
			|=> (pend_vec == 16'hFFF0) & (pend_pri == 4'h8);
	endproperty
	a_t1_vec: assert property (p_t1_vec)
		else $error("timer group took the wrong vector");
	property p_p2_vec;
		@(posedge core_clk_i) disable iff (rst_i)
		(start_fetch & !reset_src & req_p2 & !above_port)
			|=> (pend_vec == 16'hFFE6) & (pend_pri == 4'h3);
	endproperty
	a_p2_vec: assert property (p_p2_vec)
		else $error("port two took the wrong vector");
	property p_p1_vec;
		@(posedge core_clk_i) disable iff (rst_i)
		(start_fetch & !reset_src & req_p1 & !req_p2 & !above_port)
			|=> (pend_vec == 16'hFFE4) & (pend_pri == 4'h2);
	endproperty
	a_p1_vec: assert property (p_p1_vec)
		else $error("port one took the wrong vector");
	property p_gie_mask;
		@(posedge core_clk_i) disable iff (rst_i)
		(!gie & !req_nmi) |-> !start_fetch;
	endproperty
	a_gie_mask: assert property (p_gie_mask)
		else $error("maskable request passed a cleared global enable");
	property p_run;
		@(posedge core_clk_i) disable iff (rst_i)
		mode == MODE_RUN |-> clk_ctrl_o.main_cpu_clock_en
			& clk_ctrl_o.peripheral_clock_en
			& clk_ctrl_o.auxiliary_clock_en & !clk_ctrl_o.cpu_halt;
	endproperty
	a_run: assert property (p_run)
		else $error("full run stopped a clock");
	property p_l0;
		@(posedge core_clk_i) disable iff (rst_i)
		mode == MODE_L0 |-> !clk_ctrl_o.main_cpu_clock_en & clk_ctrl_o.cpu_halt
			& clk_ctrl_o.peripheral_clock_en & clk_ctrl_o.auxiliary_clock_en;
	endproperty
	a_l0: assert property (p_l0)
		else $error("level 0 gating wrong");
	property p_l1;
		@(posedge core_clk_i) disable iff (rst_i)
		mode == MODE_L1 |-> !clk_ctrl_o.main_cpu_clock_en
			& clk_ctrl_o.peripheral_clock_en
			& (clk_ctrl_o.dco_bias_en == dco_used);
	endproperty
	a_l1: assert property (p_l1)
		else $error("level 1 gating wrong");
	property p_l2;
		@(posedge core_clk_i) disable iff (rst_i)
		mode == MODE_L2 |-> !clk_ctrl_o.peripheral_clock_en
			& clk_ctrl_o.dco_bias_en & clk_ctrl_o.auxiliary_clock_en;
	endproperty
	a_l2: assert property (p_l2)
		else $error("level 2 gating wrong");
	sequence s_return;
		in_handler ##1 (!in_handler & !pending & !reset_src);
	endsequence
	property p_resume;
		@(posedge core_clk_i) disable iff (rst_i)
		(s_return ##0 sleeping) |-> clk_ctrl_o.cpu_halt;
	endproperty
	a_resume: assert property (p_resume)
		else $error("sleep level not resumed after return");
	property p_take_holds;
		@(posedge core_clk_i) disable iff (rst_i)
		(pending & !cpu_ack_i & !reset_src)
			|=> pending & $stable(pend_vec);
	endproperty
	a_take_holds: assert property (p_take_holds)
		else $error("vector request dropped before acknowledge");
	property p_no_nest;
		@(posedge core_clk_i) disable iff (rst_i)
		(in_handler & !pending & !reset_src) |=> !pending;
	endproperty
	a_no_nest: assert property (p_no_nest)
		else $error("request granted inside a handler");
	property p_reset_ctrl;
		@(posedge core_clk_i) disable iff (rst_i)
		reset_src |=> (ctrl == 8'h00) & !load_pc;
	endproperty
	a_reset_ctrl: assert property (p_reset_ctrl)
		else $error("reset source left control or pc load active");
endmodule : lowpower_interrupt_vectoring
`default_nettype wire

// >>> tb/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// cpu side: takes grants, fetches the vector word, returns from handler
module cpu_model
	import lpiv_pkg::*;
(
	input  wire logic             clk_i,        // core clock
	input  wire logic             rst_i,        // sync reset, high
	input  wire lpiv_pkg::grant_s grant_i,      // vector fetch request
	input  wire logic             pc_load_en_i, // pc load pulse
	output logic                  ack_o,        // grant accepted
	output logic                  reti_o,       // handler return pulse
	output logic [15:0]           vec_data_o    // vector word
);
	logic [15:0] last_addr;
	logic        slow;
	int          wait_n;
	int          ret_n;
	initial begin
		ack_o = 1'b0;
		reti_o = 1'b0;
		vec_data_o = 16'h0000;
	end
	// alternates a prompt and a three-cycle late acknowledge
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			reti_o <= 1'b0;
			wait_n <= 0;
			ret_n <= 0;
			slow <= 1'b0;
			last_addr <= 16'hFFFE;
			vec_data_o <= ~vec_data_o;
		end else begin
			if (ack_o) begin
				ack_o <= 1'b0;
				vec_data_o <= ~vec_data_o;
			end else if (grant_i.take && wait_n >= (slow ? 3 : 0)) begin
				ack_o <= 1'b1;
				vec_data_o <= grant_i.vector_addr ^ 16'h5AA5;
				last_addr <= grant_i.vector_addr;
				slow <= ~slow;
				wait_n <= 0;
			end else begin
				vec_data_o <= ~vec_data_o;
				if (grant_i.take)
					wait_n <= wait_n + 1;
			end
			// the reset vector starts code, it has no handler to leave
			if (pc_load_en_i && last_addr != 16'hFFFE) begin
				ret_n <= 4;
				reti_o <= 1'b0;
			end else begin
				ret_n <= (ret_n > 0) ? ret_n - 1 : 0;
				reti_o <= (ret_n == 1);
			end
		end
	end
endmodule : cpu_model
`default_nettype wire

// >>> tb/lowpower_interrupt_vectoring_test.sv
`timescale 1ns/1ps
`default_nettype none
module lowpower_interrupt_vectoring_test;
	import lpiv_pkg::*;
	logic        clk, rst, ack, reti, rd, wr, pc_en, sys_rst, irq;
	logic [3:0]  rc, addr;
	logic [7:0]  wdata, rdata;
	logic [15:0] vdata, pc;
	logic [5:0]  nmi;
	logic [19:0] per;
	grant_s      gr;
	clock_ctrl_s cc;
	int          n_errors, total_checks;
	logic [19:0] pv[9] = '{20'h80000, 20'h40000, 20'h20000, 20'h10000,
		20'h00100, 20'h08000, 20'h00001, 20'h00040, 20'h00080};
	logic [15:0] av[9] = '{16'hFFF2, 16'hFFF0, 16'hFFF0, 16'hFFF0,
		16'hFFE4, 16'hFFE4, 16'hFFE6, 16'hFFE6, 16'hFFE6};
	logic [3:0]  prv[9] = '{4'h9, 4'h8, 4'h8, 4'h8, 4'h2, 4'h2, 4'h3, 4'h3,
		4'h3};
	logic [7:0]  cv[8] = '{8'h00, 8'h80, 8'h92, 8'h90, 8'hA0, 8'hB0, 8'hC0,
		8'hF0};
	logic [5:0]  ev[8] = '{6'h3E, 6'h1F, 6'h1F, 6'h1B, 6'h0F, 6'h0B, 6'h01,
		6'h01};
	logic [7:0]  mv[8] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h10, 8'h20,
		8'h20};
	lowpower_interrupt_vectoring i_lowpower_interrupt_vectoring (
		.core_clk_i(clk), .rst_i(rst), .por_i(rc[0]), .ext_rst_i(rc[1]),
		.watchdog_flag_i(rc[2]), .flash_key_violation_flag_i(rc[3]),
		.nmi_i(nmi), .periph_i(per), .cpu_ack_i(ack), .cpu_reti_i(reti),
		.vec_data_i(vdata), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.sys_reset_o(sys_rst), .grant_o(gr), .pc_load_o(pc),
		.pc_load_en_o(pc_en), .clk_ctrl_o(cc), .irq_o(irq));
	cpu_model i_cpu_model (.clk_i(clk), .rst_i(rst), .grant_i(gr),
		.pc_load_en_i(pc_en), .ack_o(ack), .reti_o(reti), .vec_data_o(vdata));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================
	// shared tasks
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input string nm, input logic [3:0] a,
		input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(nm, {8'h00, rdata}, {8'h00, e});
	endtask : rd_chk
	task automatic grant_chk(input logic [15:0] a, input logic [3:0] p);
		int k;
		k = 0;
		while (gr.take !== 1'b1 && k < 30) begin
			@(negedge clk);
			k++;
		end
		chk("vector", gr.vector_addr, a);
		chk("prio", {12'h000, gr.priority_lvl}, {12'h000, p});
		k = 0;
		while (pc_en !== 1'b1 && k < 30) begin
			@(negedge clk);
			k++;
		end
		chk("pc", pc, a ^ 16'h5AA5);
	endtask : grant_chk
	// raise sources, expect one grant when hit is set and none otherwise, then drop them before the handler returns
	task automatic go(input logic [5:0] n, input logic [19:0] f,
		input logic [15:0] a, input logic [3:0] p, input logic hit);
		@(posedge clk);
		nmi <= n;
		per <= f;
		if (hit)
			grant_chk(a, p);
		else begin
			repeat (6) @(negedge clk);
			chk("blocked", {15'h0000, gr.take}, 16'h0000);
		end
		@(posedge clk);
		nmi <= 6'h00;
		per <= 20'h00000;
		repeat (8) @(negedge clk);
	endtask : go
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		#100000;
		n_errors++;
		tally_and_finish();
	end
	// ==========================================
	// tests
	initial begin
		n_errors = 0;
		total_checks = 0;
		rst = 1'b1;
		rc = 4'h0;
		nmi = 6'h00;
		per = 20'h00000;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		grant_chk(16'hFFFE, 4'hF);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			rc <= 4'h1 << i;
			@(negedge clk);
			chk("sysreset", {15'h0000, sys_rst}, 16'h0001);
			@(posedge clk);
			rc <= 4'h0;
			grant_chk(16'hFFFE, 4'hF);
			repeat (4) @(negedge clk);
		end
		rd_chk("ctrl", 4'h0, 8'h00);
		rd_chk("status", 4'h1, 8'h10);
		$display("test reset done");
		go(6'h24, 20'h00000, 16'hFFFC, 4'hE, 1'b1);
		go(6'h12, 20'h00000, 16'hFFFC, 4'hE, 1'b1);
		go(6'h09, 20'h00000, 16'hFFFC, 4'hE, 1'b1);
		go(6'h38, 20'h00000, 16'hFFFC, 4'hE, 1'b0);
		go(6'h00, 20'h80000, 16'hFFF2, 4'h9, 1'b0);
		wr_reg(4'h0, 8'h01);
		for (int i = 0; i < 9; i++)
			go(6'h00, pv[i], av[i], prv[i], 1'b1);
		@(posedge clk);
		nmi <= 6'h24;
		per <= 20'hFFFFF;
		grant_chk(16'hFFFC, 4'hE);
		@(posedge clk);
		nmi <= 6'h00;
		grant_chk(16'hFFF2, 4'h9);
		@(posedge clk);
		per <= 20'h7FFFF;
		grant_chk(16'hFFF0, 4'h8);
		@(posedge clk);
		per <= 20'h0FFFF;
		grant_chk(16'hFFE6, 4'h3);
		@(posedge clk);
		per <= 20'h0FF00;
		grant_chk(16'hFFE4, 4'h2);
		@(posedge clk);
		per <= 20'h00000;
		repeat (8) @(negedge clk);
		$display("test vectoring done");
		for (int i = 0; i < 8; i++) begin
			wr_reg(4'h0, cv[i]);
			@(negedge clk);
			chk("clocks", {10'h000, cc}, {10'h000, ev[i]});
			rd_chk("mode", 4'h4, mv[i]);
		end
		wr_reg(4'h0, 8'hB1);
		rd_chk("ctrl", 4'h0, 8'hB1);
		@(posedge clk);
		per <= 20'h80000;
		grant_chk(16'hFFF2, 4'h9);
		chk("awake", {10'h000, cc}, 16'h003E);
		@(posedge clk);
		per <= 20'h00000;
		repeat (8) @(negedge clk);
		chk("asleep", {10'h000, cc}, 16'h000B);
		wr_reg(4'h0, 8'h01);
		$display("test sleep done");
		wr_reg(4'h2, 8'hFF);
		wr_reg(4'h3, 8'h01);
		@(posedge clk);
		per <= 20'h00100;
		repeat (2) @(negedge clk);
		chk("irq", {15'h0000, irq}, 16'h0001);
		rd_chk("status", 4'h1, 8'h01);
		wr_reg(4'h3, 8'h00);
		@(negedge clk);
		chk("irq", {15'h0000, irq}, 16'h0000);
		wr_reg(4'h3, 8'h01);
		@(posedge clk);
		per <= 20'h00000;
		wr_reg(4'h2, 8'h01);
		@(negedge clk);
		chk("irq", {15'h0000, irq}, 16'h0000);
		rd_chk("status", 4'h1, 8'h00);
		rd_chk("unmapped", 4'hF, 8'h00);
		$display("test registers done");
		tally_and_finish();
	end
endmodule : lowpower_interrupt_vectoring_test
`default_nettype wire
